// ===== dv/pcs_pack_config_monitor.sv
// Checker for the pack config block, bound to its ports.
`timescale 1ns/1ps
module pcs_pack_config_monitor #(
    parameter int CMD_W = 16
) (
    // Clock, reset, host requests and gauge core inputs.
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_cmd_valid,
    input wire logic [CMD_W-1:0]     i_cmd_code,
    input wire pcs_pkg::pcs_df_req_s i_df_req,
    input wire pcs_pkg::pcs_pwr_e    i_power_state,
    input wire logic                 i_sleep_conditions_ok,
    input wire logic                 i_charge_term_valid,
    // Outputs under watch.
    input wire logic                 o_df_ack,
    input wire logic [15:0]          o_df_rdata,
    input wire logic                 o_sleep_allowed,
    input wire logic                 o_load_remaining_from_full,
    input wire logic [15:0]          o_ctrl_status,
    input wire logic [15:0]          o_pack_cfg,
    input wire logic                 o_shutdown_request_pin_o,
    input wire logic                 o_shutdown_request_pin_oe
);
    logic [1:0] up_cnt_r;
    logic       pu_cap_r;
    logic       pol_d_r;
    logic       hit;
    logic       sh;
    logic       e_oe;
    logic       e_o;

    // The pin only trusts the pull-up bit seen at the first edge after reset.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            up_cnt_r <= 2'h0;
            pu_cap_r <= 1'b0;
            pol_d_r  <= 1'b1;
        end
        else
        begin
            if (up_cnt_r != 2'h2)
                up_cnt_r <= up_cnt_r + 2'h1;
            if (up_cnt_r == 2'h0)
                pu_cap_r <= o_pack_cfg[3];
            pol_d_r <= o_pack_cfg[2];
        end
    end

    // Expected pin drive from the captured pull-up and last polarity.
    assign hit  = i_df_req.subclass == pcs_pkg::PCS_DF_SUBCLASS_PACK_CFG
               && i_df_req.offset == pcs_pkg::PCS_DF_OFFSET_PACK_CFG;
    assign sh   = o_ctrl_status[15];
    assign e_oe = pu_cap_r | (pol_d_r ^ sh);
    assign e_o  = pu_cap_r & (pol_d_r ~^ sh);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_pin_level_table: assert property (up_cnt_r == 2'h2 |->
        o_shutdown_request_pin_oe == e_oe
        && (!e_oe || o_shutdown_request_pin_o == e_o)) else $error("pin level");
    a_power_on_hiz: assert property ($rose(i_rst_n) |->
        !o_shutdown_request_pin_oe ##1 !o_shutdown_request_pin_oe)
        else $error("pin not released");
    a_shut_enter: assert property (up_cnt_r != 2'h0 && o_ctrl_status[7]
        && i_power_state == pcs_pkg::PCS_PWR_HIBERNATE |=> sh)
        else $error("no shutdown");
    a_shut_needs_arm: assert property (sh |-> $past(o_ctrl_status[7])
        && $past(i_power_state) == pcs_pkg::PCS_PWR_HIBERNATE)
        else $error("shutdown unexpected");
    a_arm_cmd: assert property (i_cmd_valid
        && i_cmd_code == pcs_pkg::PCS_CMD_ARM_POWER_OFF |=> o_ctrl_status[7])
        else $error("arm lost");
    a_disarm_cmd: assert property (i_cmd_valid && !o_pack_cfg[1]
        && i_cmd_code == pcs_pkg::PCS_CMD_DISARM_POWER_OFF && !i_df_req.wr
        |=> !o_ctrl_status[7]) else $error("disarm lost");
    a_write_store: assert property (i_df_req.wr && !i_df_req.rd && hit
        |=> o_df_ack && o_pack_cfg == ($past(i_df_req.wdata)
        & pcs_pkg::PCS_PACK_CFG_WMASK)) else $error("write lost");
    a_read_word: assert property (i_df_req.rd && !i_df_req.wr && hit
        |=> o_df_ack && o_df_rdata == $past(o_pack_cfg))
        else $error("read wrong");
    a_miss_silent: assert property ((i_df_req.wr || i_df_req.rd) && !hit
        |=> !o_df_ack && $stable(o_pack_cfg)) else $error("miss answered");
    a_sleep_gate: assert property (o_sleep_allowed
        == (i_sleep_conditions_ok && o_pack_cfg[5])) else $error("sleep gate");
    a_term_load: assert property (i_charge_term_valid
        |=> o_load_remaining_from_full == $past(o_pack_cfg[4]))
        else $error("term load");
endmodule // pcs_pack_config_monitor

bind pcs_pack_config pcs_pack_config_monitor #(.CMD_W(CMD_W)) u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd_code(i_cmd_code), .i_df_req(i_df_req),
    .i_power_state(i_power_state),
    .i_sleep_conditions_ok(i_sleep_conditions_ok),
    .i_charge_term_valid(i_charge_term_valid), .o_df_ack(o_df_ack),
    .o_df_rdata(o_df_rdata), .o_sleep_allowed(o_sleep_allowed),
    .o_load_remaining_from_full(o_load_remaining_from_full),
    .o_ctrl_status(o_ctrl_status), .o_pack_cfg(o_pack_cfg),
    .o_shutdown_request_pin_o(o_shutdown_request_pin_o),
    .o_shutdown_request_pin_oe(o_shutdown_request_pin_oe));

// ===== dv/pcs_power_cut_model.sv
// Behavioural power-removal circuit on the shutdown request pin.
`timescale 1ns/1ps
module pcs_power_cut_model (
    // Pin as driven by the gauge.
    input  wire logic i_pin_o,
    input  wire logic i_pin_oe,
    input  wire logic i_active_high,
    // Resolved level and power removal.
    output logic      o_level,
    output logic      o_cut
);
    // A pull-up holds a released pin high, so no stale value survives.
    assign o_level = i_pin_oe ? i_pin_o : 1'b1;
    // Power is removed once the pin sits at its active level.
    assign o_cut = (o_level == i_active_high);
endmodule // pcs_power_cut_model

// ===== dv/test_pcs_pack_config.sv
// Self-checking bench for the pack config block.
`timescale 1ns/1ps
module test_pcs_pack_config;
    logic                 i_clk;
    logic                 i_rst_n;
    logic                 i_cmd_valid;
    logic [15:0]          i_cmd_code;
    pcs_pkg::pcs_df_req_s i_df_req;
    pcs_pkg::pcs_pwr_e    i_power_state;
    logic                 i_sleep_ok;
    logic                 i_term;
    logic                 ack;
    logic [15:0]          rdata;
    pcs_pkg::pcs_cfg_s    cfg;
    logic                 sleep_allowed;
    logic [15:0]          status;
    logic [15:0]          word;
    logic                 pin_o;
    logic                 pin_oe;
    logic                 cut;
    logic [15:0]          exp_q[$];
    logic [15:0]          w;
    int                   n_mismatch = 0;
    int                   compares = 0;
    int                   seed = 97360;

    pcs_pack_config uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
        .i_df_req(i_df_req), .o_df_ack(ack), .o_df_rdata(rdata),
        .i_power_state(i_power_state), .i_sleep_conditions_ok(i_sleep_ok),
        .i_charge_term_valid(i_term), .o_cfg(cfg),
        .o_sleep_allowed(sleep_allowed), .o_load_remaining_from_full(),
        .o_ctrl_status(status), .o_pack_cfg(word),
        .o_shutdown_request_pin_o(pin_o), .o_shutdown_request_pin_oe(pin_oe));
    pcs_power_cut_model u_cut (.i_pin_o(pin_o), .i_pin_oe(pin_oe),
        .i_active_high(word[2]), .o_level(), .o_cut(cut));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Data flash access; the expected read data is queued for the watcher.
    task automatic df(input logic wr, input logic [7:0] sub,
                      input logic [15:0] d, input logic [15:0] e);
        @(negedge i_clk);
        i_df_req = '{wr, !wr, sub, 8'h00, d};
        if (sub == pcs_pkg::PCS_DF_SUBCLASS_PACK_CFG)
            exp_q.push_back(e);
        @(negedge i_clk);
        i_df_req = '0;
    endtask

    task automatic cmd(input logic [15:0] c);
        @(negedge i_clk);
        i_cmd_valid = 1'b1;
        i_cmd_code  = c;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
    endtask

    task automatic pin(input logic pu, input logic pol, input logic sh);
        chk(16'({pin_oe, pin_oe & pin_o}),
            16'({pu | (pol ^ sh), (pu | (pol ^ sh)) & pu & (pol ~^ sh)}));
        chk(16'({status[15], cut}), 16'({sh, sh}));
    endtask

    task automatic do_reset;
        @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        chk(word, pcs_pkg::PCS_PACK_CFG_RESET);
        chk(status, 16'h0080);
        chk(16'(pin_oe), 16'h0000);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        pin(1'b0, 1'b1, 1'b0);
        $display("test reset done");
    endtask

    task automatic summarize;
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Free-running clock of 100 ns period.
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // Each acknowledge takes the oldest queued expectation.
    always @(negedge i_clk)
        if (ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(16'h0001, 16'h0000);
            else
                chk(rdata, exp_q.pop_front());
        end

    // Cut a hang short well past the expected run length.
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    // Main sequence.
    initial
    begin
        {i_rst_n, i_cmd_valid, i_cmd_code, i_df_req, i_sleep_ok, i_term} = '0;
        i_power_state = pcs_pkg::PCS_PWR_NORMAL;
        do_reset();
        for (int i = 0; i < 6; i++)
        begin
            w = 16'($random(seed));
            df(1'b1, 8'h40, w, 16'h0000);
            df(1'b0, 8'h40, 16'h0000, w & 16'h8f7f);
            df(1'b0, 8'h41, 16'h0000, 16'h0000);
            chk(16'(cfg), 16'({w[15], w[11:8], w[6], w[4], w[0]}));
            {i_sleep_ok, i_term} = 2'($random(seed));
            @(negedge i_clk);
            chk(16'(sleep_allowed), 16'(i_sleep_ok & w[5]));
            i_term = 1'b0;
        end
        $display("test config done");
        for (int p = 0; p < 2; p++)
        begin
            df(1'b1, 8'h40, 16'h0138 | 16'(p << 2), 16'h0000);
            cmd(pcs_pkg::PCS_CMD_DISARM_POWER_OFF);
            cmd(16'h0015);
            chk(16'(status[7]), 16'h0000);
            i_power_state = pcs_pkg::PCS_PWR_HIBERNATE;
            @(negedge i_clk);
            pin(1'b0, 1'(p), 1'b0);
            cmd(pcs_pkg::PCS_CMD_ARM_POWER_OFF);
            chk(16'(status[7]), 16'h0001);
            @(negedge i_clk);
            pin(1'b0, 1'(p), 1'b1);
            i_power_state = pcs_pkg::PCS_PWR_SLEEP;
            @(negedge i_clk);
            pin(1'b0, 1'(p), 1'b0);
            cmd(pcs_pkg::PCS_CMD_DISARM_POWER_OFF);
            df(1'b1, 8'h40, 16'h0002, 16'h0000);
            chk(16'(status[7]), 16'h0001);
        end
        $display("test arming done");
        i_power_state = pcs_pkg::PCS_PWR_NORMAL;
        do_reset();
        summarize();
    end
endmodule // test_pcs_pack_config

// ===== include/pcs_pkg.sv
// Package: constants, field layout and carrier types of the pack config block.
package pcs_pkg;

    // Host control subcommand codes.
    localparam logic [15:0] PCS_CMD_ARM_POWER_OFF    = 16'h0013;
    localparam logic [15:0] PCS_CMD_DISARM_POWER_OFF = 16'h0014;

    // Data flash location of the pack configuration word.
    localparam logic [7:0]  PCS_DF_SUBCLASS_PACK_CFG = 8'h40;
    localparam logic [7:0]  PCS_DF_OFFSET_PACK_CFG   = 8'h00;

    // Pack configuration word: reset value and writable bits.
    localparam logic [15:0] PCS_PACK_CFG_RESET       = 16'h0177;
    localparam logic [15:0] PCS_PACK_CFG_WMASK       = 16'h8f7f;

    // Field positions inside the 16-bit pack configuration word.
    localparam int PCS_BIT_RESERVE_NOLOAD_COMP   = 15;
    localparam int PCS_BIT_ADC_GROUND_CHOICE     = 11;
    localparam int PCS_BIT_WAKE_THRESHOLD_SEL    = 10;
    localparam int PCS_BIT_SENSE_RANGE_HI        = 9;
    localparam int PCS_BIT_SENSE_RANGE_LO        = 8;
    localparam int PCS_BIT_RA_STEP_LIMIT         = 6;
    localparam int PCS_BIT_SLEEP_PERMIT          = 5;
    localparam int PCS_BIT_REMAINING_FROM_FULL   = 4;
    localparam int PCS_BIT_PIN_DRIVE_PULLUP      = 3;
    localparam int PCS_BIT_PIN_POLARITY          = 2;
    localparam int PCS_BIT_POWER_OFF_CFG_ENABLE  = 1;
    localparam int PCS_BIT_THERMISTOR_SOURCE     = 0;

    // Control status word bit positions.
    localparam int PCS_STAT_BIT_PIN_ACTIVE       = 15;
    localparam int PCS_STAT_BIT_POWER_OFF_ARMED  = 7;

    // Values after reset of the status flags.
    localparam logic PCS_PIN_ACTIVE_RESET        = 1'b0;
    localparam logic PCS_ARMED_RESET             = 1'b1;

    // Power state reported by the gauge core, one-hot.
    typedef enum logic [2:0] {
        PCS_PWR_NORMAL    = 3'b001,
        PCS_PWR_SLEEP     = 3'b010,
        PCS_PWR_HIBERNATE = 3'b100
    } pcs_pwr_e;

    // Shutdown pin driver state, one-hot.
    typedef enum logic [2:0] {
        PCS_PIN_POR_HIZ  = 3'b001,
        PCS_PIN_NORMAL   = 3'b010,
        PCS_PIN_SHUTDOWN = 3'b100
    } pcs_pin_e;

    // Decoded configuration handed to the gauge core.
    typedef struct packed {
        logic       reserve_noload_comp;
        logic       adc_ground_choice;
        logic       wake_threshold_sel;
        logic       sense_range_hi;
        logic       sense_range_lo;
        logic       ra_step_limit;
        logic       remaining_from_full_on_term;
        logic       thermistor_source;
    } pcs_cfg_s;

    // Data flash access from the host command interface.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  subclass;
        logic [7:0]  offset;
        logic [15:0] wdata;
    } pcs_df_req_s;

endpackage

// ===== rtl/pcs_pack_config.sv
// Pack configuration word, power-off arming and shutdown pin driver.
`timescale 1ns/1ps

// How it works
// - Status bit 15 flags shutdown pin active.
// - Status bit 7 shows power-off armed, resets 1.
// - Subcommand 0x0013 sets the armed bit.
// - Subcommand 0x0014 clears the armed bit.
// - Config enable bit set also sets armed.
// - Shutdown level only in hibernate state.
// - Pull-up/polarity pair selects pin levels.
// - Pin is high impedance at power-on reset.
// - Pull-up change applies only after reset.
// - Config word at subclass 64 offset 0.
// - Low byte bit3 pull-up, bit2 polarity.
// - High bit7 selects no-load reserve compensation.
// - High bit3 chooses alternate ADC ground.
// - High bits 2..0 set wake detection.
// - Low bit6 enables resistance step limiting.
// - Sleep allowed only with permission bit.
// - Load remaining from full on termination.
// - Polarity clear active low, set active high.
// - Pull-up set push-pull, clear open drain.
// - Config enable bit defaults to one.
// - Low bit0 selects external thermistor source.
module pcs_pack_config #(
    parameter int CMD_W = 16
) (
    // Clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Host control subcommand.
    input  wire logic                 i_cmd_valid,
    input  wire logic [CMD_W-1:0]     i_cmd_code,
    // Host data flash access.
    input  wire pcs_pkg::pcs_df_req_s i_df_req,
    output logic                      o_df_ack,
    output logic [15:0]               o_df_rdata,
    // Gauge core status and events.
    input  wire pcs_pkg::pcs_pwr_e    i_power_state,
    input  wire logic                 i_sleep_conditions_ok,
    input  wire logic                 i_charge_term_valid,
    // Decoded configuration and actions.
    output pcs_pkg::pcs_cfg_s         o_cfg,
    output logic                      o_sleep_allowed,
    output logic                      o_load_remaining_from_full,
    output logic [15:0]               o_ctrl_status,
    output logic [15:0]               o_pack_cfg,
    // Shutdown request pin, open drain or push-pull.
    output logic                      o_shutdown_request_pin_o,
    output logic                      o_shutdown_request_pin_oe
);

    // The subcommand codes are 16 bits wide; a narrower port cannot hold them.
    generate
        if (CMD_W < 16)
        begin : g_bad_width
            $error("pcs_pack_config: CMD_W must be at least 16");
        end
    endgenerate

    logic [15:0]        pack_cfg_r;
    logic               armed_r;
    logic               pullup_live_r;
    logic               captured_r;
    pcs_pkg::pcs_pin_e  pin_state_r;
    pcs_pkg::pcs_pin_e  pin_state_nxt;
    logic               pin_o_r;
    logic               pin_oe_r;
    logic               pin_o_nxt;
    logic               pin_oe_nxt;
    logic               df_hit;
    logic               df_write;
    logic               cmd_arm;
    logic               cmd_disarm;
    logic               cfg_enable_write;
    logic               polarity;
    logic               shutdown_wanted;

    // The block answers a single data flash location. Every other subclass
    // or offset belongs to storage kept elsewhere in the gauge, so a miss
    // must neither store nor acknowledge; the host side then times out or
    // is answered by whichever block owns that location.
    // Address decode of the data flash window for the configuration word.
    assign df_hit = (i_df_req.subclass == pcs_pkg::PCS_DF_SUBCLASS_PACK_CFG)
                 && (i_df_req.offset == pcs_pkg::PCS_DF_OFFSET_PACK_CFG);
    assign df_write = i_df_req.wr && df_hit;

    // Codes other than arm and disarm fall through silently, since other
    // blocks of the gauge decode the rest of the subcommand space.
    // Subcommand decode; only the low 16 bits carry a code.
    assign cmd_arm    = i_cmd_valid
                     && (i_cmd_code[15:0] == pcs_pkg::PCS_CMD_ARM_POWER_OFF);
    assign cmd_disarm = i_cmd_valid
                     && (i_cmd_code[15:0] == pcs_pkg::PCS_CMD_DISARM_POWER_OFF);

    // A write carrying the enable bit arms the feature just as the command.
    assign cfg_enable_write = df_write
        && i_df_req.wdata[pcs_pkg::PCS_BIT_POWER_OFF_CFG_ENABLE];

    // The stored word feeds the decoded fields, the sleep gate and the pin
    // polarity at once. Reserved positions are masked on the way in so that
    // a careless host image cannot make them read back as ones later.
    // There is no flash model here: a reset always brings back the default
    // word, which a system with real flash would instead reload from storage.
    // Configuration word storage; reserved bits are never stored.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pack_cfg_r <= pcs_pkg::PCS_PACK_CFG_RESET;
        end
        else if (df_write)
        begin
            pack_cfg_r <= i_df_req.wdata & pcs_pkg::PCS_PACK_CFG_WMASK;
        end
    end

    // The acknowledge is registered, which costs one cycle of latency but
    // keeps the decode path off the host interface timing. Read data is
    // forced to zero outside a hitting read so that an idle bus carries no
    // stale copy of the word.
    // Read back of the word one cycle after the request.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_df_ack   <= 1'b0;
            o_df_rdata <= 16'h0000;
        end
        else
        begin
            o_df_ack   <= (i_df_req.rd || i_df_req.wr) && df_hit;
            o_df_rdata <= (i_df_req.rd && df_hit) ? pack_cfg_r : 16'h0000;
        end
    end

    // The armed flag has two setters and one clearer. Only a write that
    // carries the enable bit arms the feature; a stored enable bit alone
    // does not keep re-arming it, otherwise the disarm subcommand could
    // never take hold under the default word.
    // Armed flag. Arming wins over a disarm in the same cycle so that an
    // enable request is never lost behind a racing disarm.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            armed_r <= pcs_pkg::PCS_ARMED_RESET;
        end
        else if (cmd_arm || cfg_enable_write)
        begin
            armed_r <= 1'b1;
        end
        else if (cmd_disarm)
        begin
            armed_r <= 1'b0;
        end
    end

    // Switching the pad between open drain and push-pull while the external
    // circuit watches the pin could glitch it towards its cut level, which
    // is why the pull-up choice is frozen until the next reset.
    // The pull-up choice is caught once, on the first edge after reset
    // release, and then frozen; later writes wait for the next reset.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            captured_r    <= 1'b0;
            pullup_live_r <= 1'b0;
        end
        else if (!captured_r)
        begin
            captured_r    <= 1'b1;
            pullup_live_r <= pack_cfg_r[pcs_pkg::PCS_BIT_PIN_DRIVE_PULLUP];
        end
    end

    // Polarity follows the stored word at once, unlike the pull-up.
    assign polarity = pack_cfg_r[pcs_pkg::PCS_BIT_PIN_POLARITY];

    // Shutdown level needs the feature armed and the hibernate state.
    assign shutdown_wanted = armed_r
        && (i_power_state == pcs_pkg::PCS_PWR_HIBERNATE);

    // The hi-Z state after reset protects the power path: until the pull-up
    // choice is known, driving either level could be read as a shutdown
    // request by the external circuit. The state machine therefore waits
    // one edge for the capture before it picks normal or shutdown.
    // The reset state is never entered again without a reset.
    // Pin state machine: leaves the reset hi-Z state only after capture.
    always_comb
    begin
        pin_state_nxt = pin_state_r;
        unique case (pin_state_r)
            pcs_pkg::PCS_PIN_POR_HIZ:
            begin
                if (captured_r)
                begin
                    pin_state_nxt = shutdown_wanted ? pcs_pkg::PCS_PIN_SHUTDOWN
                                                    : pcs_pkg::PCS_PIN_NORMAL;
                end
            end
            pcs_pkg::PCS_PIN_NORMAL:
            begin
                if (shutdown_wanted)
                begin
                    pin_state_nxt = pcs_pkg::PCS_PIN_SHUTDOWN;
                end
            end
            pcs_pkg::PCS_PIN_SHUTDOWN:
            begin
                if (!shutdown_wanted)
                begin
                    pin_state_nxt = pcs_pkg::PCS_PIN_NORMAL;
                end
            end
            default:
            begin
                pin_state_nxt = pcs_pkg::PCS_PIN_POR_HIZ;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_state_r <= pcs_pkg::PCS_PIN_POR_HIZ;
        end
        else
        begin
            pin_state_r <= pin_state_nxt;
        end
    end

    // The table is computed from the next state rather than the current one
    // so that the pad and the pin-active status bit change on the same edge
    // and the host never sees the two disagree.
    // Level table for the next pin state. Without pull-up the pin is open
    // drain, so a high level becomes released (oe low).
    always_comb
    begin
        pin_o_nxt  = 1'b0;
        pin_oe_nxt = 1'b0;
        unique case (pin_state_nxt)
            pcs_pkg::PCS_PIN_POR_HIZ:
            begin
                pin_o_nxt  = 1'b0;
                pin_oe_nxt = 1'b0;
            end
            pcs_pkg::PCS_PIN_NORMAL:
            begin
                pin_o_nxt  = pullup_live_r && !polarity;
                pin_oe_nxt = pullup_live_r || polarity;
            end
            pcs_pkg::PCS_PIN_SHUTDOWN:
            begin
                pin_o_nxt  = pullup_live_r && polarity;
                pin_oe_nxt = pullup_live_r || !polarity;
            end
            default:
            begin
                pin_o_nxt  = 1'b0;
                pin_oe_nxt = 1'b0;
            end
        endcase
    end

    // Registered pin drivers keep the pad free of decode glitches.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_o_r  <= 1'b0;
            pin_oe_r <= 1'b0;
        end
        else
        begin
            pin_o_r  <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign o_shutdown_request_pin_o  = pin_o_r;
    assign o_shutdown_request_pin_oe = pin_oe_r;

    // Only two positions of the status word belong to this block; the rest
    // read zero here and are merged with other status sources upstream.
    // Control status word; pin-active tracks the shutdown state flop.
    always_comb
    begin
        o_ctrl_status = 16'h0000;
        o_ctrl_status[pcs_pkg::PCS_STAT_BIT_PIN_ACTIVE] =
            (pin_state_r == pcs_pkg::PCS_PIN_SHUTDOWN);
        o_ctrl_status[pcs_pkg::PCS_STAT_BIT_POWER_OFF_ARMED] = armed_r;
    end

    // These fields take effect on the cycle after a write. The gauge core
    // must tolerate a field that changes in mid-computation, since no
    // shadow copy is kept to hold them steady until a safe point.
    // Decoded fields for the gauge core, straight from the stored word.
    always_comb
    begin
        o_cfg.reserve_noload_comp =
            pack_cfg_r[pcs_pkg::PCS_BIT_RESERVE_NOLOAD_COMP];
        o_cfg.adc_ground_choice =
            pack_cfg_r[pcs_pkg::PCS_BIT_ADC_GROUND_CHOICE];
        o_cfg.wake_threshold_sel =
            pack_cfg_r[pcs_pkg::PCS_BIT_WAKE_THRESHOLD_SEL];
        o_cfg.sense_range_hi =
            pack_cfg_r[pcs_pkg::PCS_BIT_SENSE_RANGE_HI];
        o_cfg.sense_range_lo =
            pack_cfg_r[pcs_pkg::PCS_BIT_SENSE_RANGE_LO];
        o_cfg.ra_step_limit =
            pack_cfg_r[pcs_pkg::PCS_BIT_RA_STEP_LIMIT];
        o_cfg.remaining_from_full_on_term =
            pack_cfg_r[pcs_pkg::PCS_BIT_REMAINING_FROM_FULL];
        o_cfg.thermistor_source =
            pack_cfg_r[pcs_pkg::PCS_BIT_THERMISTOR_SOURCE];
    end

    assign o_pack_cfg = pack_cfg_r;

    // Sleep permission gates the core's own sleep qualification.
    assign o_sleep_allowed = i_sleep_conditions_ok
        && pack_cfg_r[pcs_pkg::PCS_BIT_SLEEP_PERMIT];

    // A termination pulse that arrives while the bit is clear is dropped,
    // not remembered; setting the bit later does not replay it.
    // One-cycle command to copy full charge capacity into remaining.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_load_remaining_from_full <= 1'b0;
        end
        else
        begin
            o_load_remaining_from_full <= i_charge_term_valid
                && pack_cfg_r[pcs_pkg::PCS_BIT_REMAINING_FROM_FULL];
        end
    end

endmodule // pcs_pack_config
